/* File: logic/ilu_top.sv */
/*
  Interrupt latch and enable unit: pending latches for sources 15..2, a 16-bit
  enable register with the global enable at bit 0, request selection and the
  stacking of the global enable on acceptance.
  Assumes the CPU core drives byte-wide special-function accesses, one-cycle
  instruction pulses and a one-cycle accept pulse with the accepted source id.
*/
`timescale 1ns/100ps
`include "ilu_regs.svh"

module ilu_top (
	input  wire  logic             sys_clk,
	input  wire  logic             reset,
	input  wire  logic [7:0]       sfr_addr,
	input  wire  logic             sfr_wr,
	input  wire  logic             sfr_rd,
	input  wire  logic [7:0]       sfr_wdata,
	output logic [7:0]             sfr_rdata,
	input  wire  logic [15:2]      irq_src,
	input  wire  logic             cpu_ack,
	input  wire  ilu_pkg::ilu_id_t cpu_ack_id,
	input  wire  logic             unmask_all_instr,
	input  wire  logic             mask_all_instr,
	input  wire  logic             return_from_maskable,
	input  wire  logic             return_from_nmi,
	input  wire  logic             ret_imf,
	output logic                   int_req,
	output ilu_pkg::ilu_id_t       int_id,
	output logic                   pushed_imf
);
	import ilu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	ilu_state_s st_reg;
	ilu_state_s st_next;
	logic [3:0] sel;
	ilu_word_t  eligible;
	ilu_word_t  set_vec;
	ilu_word_t  sw_clr;
	ilu_word_t  ack_clr;
	logic       ret_any;

	// one-hot select of the four bytes; bit order: en low, en high, latch low, latch high
	function automatic logic [3:0] ilu_decode(input logic [7:0] a);
		ilu_decode = {a == `ILU_LATCH_HIGH_ADDR, a == `ILU_LATCH_LOW_ADDR,
			a == `ILU_ENABLE_HIGH_ADDR, a == `ILU_ENABLE_LOW_ADDR};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// request eligibility and selection

	assign sel     = ilu_decode(sfr_addr);
	assign set_vec = {irq_src, 2'b00};
	// both return flavours restore the global enable the same way
	assign ret_any = return_from_maskable | return_from_nmi;

	// maskable positions need all three terms; trap and watchdog need only the latch
	// ids 0 and 1 never come from here: software and undefined traps live in the core
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_elig
			if (g >= `ILU_FIRST_MASKABLE) begin : g_mask
				assign eligible[g] = st_reg.latch[g] & st_reg.enable[g]
					& st_reg.enable[`ILU_GLOBAL_EN_BIT];
			end else if (g >= `ILU_TRAP_POS) begin : g_nmi
				assign eligible[g] = st_reg.latch[g];
			end else begin : g_none
				assign eligible[g] = 1'b0;
			end
		end
	endgenerate

	// lowest number wins; request lines derive only from registers
	ilu_prio u_prio (
		.eligible (eligible),
		.valid    (int_req),
		.id       (int_id)
	);

	// the core pushes the stacked value after the acceptance edge; it stands until the next
	assign sfr_rdata  = st_reg.rdata;
	assign pushed_imf = st_reg.stacked;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;

		// software clear: zeros in the written byte clear, ones leave the latch alone
		// a read-modify-write can still lose a request landing between its read and
		// its write; the set-wins rule only covers requests in the write cycle itself
		sw_clr = 16'h0000;
		if (sfr_wr && sel[2]) begin
			sw_clr[7:0] = ~sfr_wdata;
		end
		if (sfr_wr && sel[3]) begin
			sw_clr[15:8] = ~sfr_wdata;
		end
		sw_clr = sw_clr & `ILU_LATCH_WMASK;

		// acceptance clears only the accepted latch; ids 0 and 1 own none
		// the accept id is trusted as given: the core should ack only what int_id showed
		ack_clr = 16'h0000;
		if (cpu_ack && (cpu_ack_id >= `ILU_FIRST_LATCH_ID)) begin
			ack_clr[cpu_ack_id] = 1'b1;
		end

		// set wins over both clears so no request is dropped; writes never set
		st_next.latch = ((st_reg.latch & ~(sw_clr | ack_clr)) | set_vec)
			& `ILU_LATCH_WMASK;

		// enable bytes; unimplemented bits are masked away
		if (sfr_wr && sel[0]) begin
			st_next.enable[7:0] = sfr_wdata;
		end
		if (sfr_wr && sel[1]) begin
			st_next.enable[15:8] = sfr_wdata;
		end
		st_next.enable = st_next.enable & `ILU_ENABLE_WMASK;

		// global enable: later statements take precedence over the write above
		if (unmask_all_instr) begin
			st_next.enable[`ILU_GLOBAL_EN_BIT] = 1'b1;
		end
		if (mask_all_instr) begin
			st_next.enable[`ILU_GLOBAL_EN_BIT] = 1'b0;
		end
		if (ret_any) begin
			st_next.enable[`ILU_GLOBAL_EN_BIT] = ret_imf;
		end
		// acceptance beats everything: the old value is stacked, then cleared
		if (cpu_ack) begin
			st_next.stacked = st_reg.enable[`ILU_GLOBAL_EN_BIT];
			st_next.enable[`ILU_GLOBAL_EN_BIT] = 1'b0;
		end

		// read data is captured at the read strobe; unmapped offsets read zero
		// registering the read costs a cycle of latency but keeps the bus output glitch free
		if (sfr_rd) begin
			case (sel)
				4'b0001: st_next.rdata = st_reg.enable[7:0];
				4'b0010: st_next.rdata = st_reg.enable[15:8];
				4'b0100: st_next.rdata = st_reg.latch[7:0];
				4'b1000: st_next.rdata = st_reg.latch[15:8];
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// every latch and enable starts at zero so only trap and watchdog are accepted before setup
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_reg.latch   <= `ILU_LATCH_RESET;
			st_reg.enable  <= `ILU_ENABLE_RESET;
			st_reg.rdata   <= 8'h00;
			st_reg.stacked <= `ILU_STACKED_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	// all checks sample on the rising edge and sleep through reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// accepted latch drops next cycle unless a fresh request arrived
	a_ack_clears_latch: assert property (
		(cpu_ack && (cpu_ack_id >= `ILU_FIRST_LATCH_ID) && !set_vec[cpu_ack_id])
		|=> !st_reg.latch[$past(cpu_ack_id)])
		else $error("accepted latch not cleared");

	// every incoming request is held, whatever clears coincide
	a_request_sets_latch: assert property (
		(set_vec != 16'h0000) |=> ((st_reg.latch & $past(set_vec)) == $past(set_vec)))
		else $error("request not latched");

	// a latch can only rise from a request
	a_write_never_sets: assert property (
		1'b1 |=> ((st_reg.latch & ~$past(st_reg.latch | set_vec)) == 16'h0000))
		else $error("latch set without a request");

	// a low-byte write clears exactly the zero bits and leaves the high byte
	a_sw_clear_exact: assert property (
		(sfr_wr && sel[2] && (set_vec == 16'h0000) && !cpu_ack)
		|=> ((st_reg.latch[7:0] == ($past(st_reg.latch[7:0]) & $past(sfr_wdata) & 8'hfc))
		&& (st_reg.latch[15:8] == $past(st_reg.latch[15:8]))))
		else $error("software clear hit wrong latches");

	// stacked value and cleared global enable after acceptance
	a_imf_stacked: assert property (
		cpu_ack |=> ((pushed_imf == $past(st_reg.enable[0])) && !st_reg.enable[0]))
		else $error("global enable not stacked and cleared");

	// a return reloads the popped value
	a_return_restores: assert property (
		(ret_any && !cpu_ack) |=> (st_reg.enable[0] == $past(ret_imf)))
		else $error("return did not restore global enable");

	// without the global enable only trap and watchdog are presented
	a_global_blocks: assert property (
		(!st_reg.enable[0] && int_req) |-> (int_id < 4'h4))
		else $error("maskable request with global enable off");

	// a pending trap is presented first regardless of the enables
	a_trap_ungated: assert property (
		st_reg.latch[`ILU_TRAP_POS] |-> (int_req && (int_id == 4'h2)))
		else $error("trap request not presented");

	// nothing eligible below the presented id
	a_lowest_first: assert property (
		int_req |-> ((eligible & ((16'h0001 << int_id) - 16'h0001)) == 16'h0000))
		else $error("priority order violated");

	// unimplemented bits stay zero
	a_reserved_zero: assert property (
		(st_reg.enable[3:1] == 3'h0) && (st_reg.latch[1:0] == 2'h0))
		else $error("unimplemented bit set");

	// a low latch read returns the pending state of the cycle of the strobe
	a_read_latches: assert property (
		(sfr_rd && sel[2]) |=> (sfr_rdata == $past(st_reg.latch[7:0])))
		else $error("latch read mismatch");

	// low enable reads return the register as it stood at the strobe
	a_read_enable: assert property (
		(sfr_rd && sel[0]) |=> (sfr_rdata == $past(st_reg.enable[7:0])))
		else $error("enable read mismatch");

	// offsets outside the four bytes read as zero
	a_unmapped_zero: assert property (
		(sfr_rd && (sel == 4'h0)) |=> (sfr_rdata == 8'h00))
		else $error("unmapped offset read nonzero");

	// read data stands until the next read strobe
	a_rdata_holds: assert property (
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");

	// a high-byte write clears exactly the zero bits and leaves the low byte
	a_high_clear_exact: assert property (
		(sfr_wr && sel[3] && (set_vec == 16'h0000) && !cpu_ack)
		|=> ((st_reg.latch[15:8] == ($past(st_reg.latch[15:8]) & $past(sfr_wdata)))
		&& (st_reg.latch[7:0] == $past(st_reg.latch[7:0]))))
		else $error("high-byte clear hit wrong latches");

	// with no clear of any kind a pending latch stays pending
	a_latch_holds: assert property (
		(!(sfr_wr && (sel[2] || sel[3])) && !cpu_ack)
		|=> ((st_reg.latch & $past(st_reg.latch)) == $past(st_reg.latch)))
		else $error("latch dropped without a clear");

	// acceptance drops no latch other than the accepted one
	a_ack_only_one: assert property (
		(cpu_ack && !(sfr_wr && (sel[2] || sel[3])))
		|=> ((($past(st_reg.latch) & ~st_reg.latch)
		& ~(16'h0001 << $past(cpu_ack_id))) == 16'h0000))
		else $error("acceptance cleared a foreign latch");

	// a presented maskable source is latched, enabled and globally enabled
	a_enable_gate: assert property (
		(int_req && (int_id >= 4'h4))
		|-> (st_reg.latch[int_id] && st_reg.enable[int_id] && st_reg.enable[0]))
		else $error("maskable request presented while gated");

	// any due source, maskable or not, raises the request line
	a_request_when_due: assert property (
		((st_reg.latch & (({16{st_reg.enable[0]}} & st_reg.enable) | 16'h000c)) != 16'h0000)
		|-> int_req)
		else $error("due request not presented");

	// an idle request line reports id zero
	a_idle_id_zero: assert property (
		!int_req |-> (int_id == 4'h0))
		else $error("id shown without a request");

	// the stacked value only moves at an acceptance
	a_stack_holds: assert property (
		!cpu_ack |=> $stable(pushed_imf))
		else $error("stacked value changed without acceptance");

	// the unmask pulse sets the global enable when nothing stronger coincides
	a_unmask_sets: assert property (
		(unmask_all_instr && !mask_all_instr && !ret_any && !cpu_ack)
		|=> st_reg.enable[`ILU_GLOBAL_EN_BIT])
		else $error("unmask did not set global enable");

	// the mask pulse clears the global enable unless a return or acceptance wins
	a_mask_clears: assert property (
		(mask_all_instr && !ret_any && !cpu_ack)
		|=> !st_reg.enable[`ILU_GLOBAL_EN_BIT])
		else $error("mask did not clear global enable");

	// a low enable write lands with bits 3..1 dropped
	a_enable_low_write: assert property (
		(sfr_wr && sel[0] && !unmask_all_instr && !mask_all_instr && !ret_any && !cpu_ack)
		|=> (st_reg.enable[7:0] == ($past(sfr_wdata) & 8'hf1)))
		else $error("low enable write mismatch");

	// a high enable write lands whole
	a_enable_high_write: assert property (
		(sfr_wr && sel[1]) |=> (st_reg.enable[15:8] == $past(sfr_wdata)))
		else $error("high enable write mismatch");

	// main scenarios
	c_set_vs_clear: cover property (sfr_wr && sel[2] && (set_vec != 16'h0000));
	c_maskable_ack: cover property (int_req && (int_id >= 4'h4) ##1 cpu_ack);
	c_trap_ack: cover property (cpu_ack && (cpu_ack_id == 4'h2));
	c_ack_then_return: cover property (cpu_ack ##[1:20] return_from_maskable);
	c_trap_and_wdog: cover property (st_reg.latch[`ILU_TRAP_POS] && st_reg.latch[`ILU_WDOG_POS]);

endmodule

/* File: logic/ilu_regs.svh */
/*
  Register offsets, bit positions, reset values and write masks of the interrupt
  latch and enable unit.
  Assumes byte-wide special-function addressing with an 8-bit offset.
*/
`ifndef ILU_REGS_SVH
`define ILU_REGS_SVH

// special-function byte offsets
`define ILU_ENABLE_LOW_ADDR   8'h3a
`define ILU_ENABLE_HIGH_ADDR  8'h3b
`define ILU_LATCH_LOW_ADDR    8'h3c
`define ILU_LATCH_HIGH_ADDR   8'h3d

// reset values
`define ILU_ENABLE_RESET      16'h0000
`define ILU_LATCH_RESET       16'h0000
`define ILU_STACKED_RESET     1'b0

// field positions
`define ILU_GLOBAL_EN_BIT     0
`define ILU_TRAP_POS          2
`define ILU_WDOG_POS          3
`define ILU_FIRST_MASKABLE    4
`define ILU_LAST_SOURCE       15

// implemented bits: enable 15..4 and 0, latches 15..2
`define ILU_ENABLE_WMASK      16'hfff1
`define ILU_LATCH_WMASK       16'hfffc

// lowest accept identifier that owns a latch
`define ILU_FIRST_LATCH_ID    4'h2

`endif

/* File: logic/ilu_pkg.sv */
/*
  Types shared by the interrupt latch and enable unit.
  Assumes the constants of ilu_regs.svh.
*/
package ilu_pkg;

	typedef logic [15:0] ilu_word_t;
	typedef logic [7:0]  ilu_byte_t;
	typedef logic [3:0]  ilu_id_t;

	// whole state of the unit, registered in one place
	typedef struct packed {
		ilu_word_t latch;
		ilu_word_t enable;
		ilu_byte_t rdata;
		logic      stacked;
	} ilu_state_s;

endpackage

/* File: logic/ilu_prio.sv */
/*
  Fixed-priority selector: picks the lowest-numbered eligible request.
  Assumes eligibility is already gated by the enables in the caller.
*/
`timescale 1ns/100ps

module ilu_prio (
	input  wire  logic [15:0]      eligible,
	output logic                   valid,
	output ilu_pkg::ilu_id_t       id
);
	import ilu_pkg::*;

	// scan from the top so the lowest index written last wins
	always_comb begin
		valid = 1'b0;
		id    = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (eligible[i]) begin
				valid = 1'b1;
				id    = 4'(i);
			end
		end
	end

endmodule

/* File: sim/ilu_cpu_model.sv */
/*
  CPU core model: pulses acceptance and returns, keeps the stacked global enable.
  Assumes its tasks are entered one small delay after a rising edge of sys_clk.
*/
`timescale 1ns/100ps

module ilu_cpu_model (
	input  wire  logic       sys_clk,
	input  wire  logic       pushed_imf,
	output logic             cpu_ack,
	output ilu_pkg::ilu_id_t cpu_ack_id,
	output logic             ret_mask,
	output logic             ret_nmi,
	output logic             ret_imf
);
	import ilu_pkg::*;

	logic stack_q[$];

	initial begin
		cpu_ack = 1'b0;
		cpu_ack_id = 4'h0;
		ret_mask = 1'b0;
		ret_nmi = 1'b0;
		ret_imf = 1'b0;
	end

	// one-cycle acceptance; the pushed value is taken after the unit captured it
	task automatic accept(input ilu_id_t id);
		cpu_ack = 1'b1;
		cpu_ack_id = id;
		@(posedge sys_clk);
		#1;
		cpu_ack = 1'b0;
		cpu_ack_id = ~id; // released id must not keep the old value
		stack_q.push_back(pushed_imf);
		// one idle edge so back-to-back calls never retoggle the strobe in one step
		@(posedge sys_clk);
		#1;
	endtask

	// one-cycle return; popped value is inverted afterwards so stale reuse shows
	task automatic ret(input logic nmi);
		ret_imf = stack_q.pop_back();
		ret_nmi = nmi;
		ret_mask = ~nmi;
		@(posedge sys_clk);
		#1;
		ret_nmi = 1'b0;
		ret_mask = 1'b0;
		ret_imf = ~ret_imf;
		// one idle edge so back-to-back calls never retoggle the strobe in one step
		@(posedge sys_clk);
		#1;
	endtask
endmodule

/* File: sim/interrupt_latch_enable_unit_tb_top.sv */
/*
  Self-checking bench of the interrupt latch and enable unit.
  Assumes ilu_top, ilu_cpu_model and the register offsets header.
*/
`timescale 1ns/100ps
`include "ilu_regs.svh"

module interrupt_latch_enable_unit_tb_top;
	import ilu_pkg::*;

	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic [15:2] irq_src = '0;
	logic        unmask = 1'b0;
	logic        mask = 1'b0;
	logic        cpu_ack, ret_mask, ret_nmi, ret_imf, int_req, pushed_imf;
	ilu_id_t     cpu_ack_id, int_id;
	int          fail_count = 0;
	int          tests_run = 0;

	always #4 sys_clk = ~sys_clk;

	ilu_top uut (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_src(irq_src),
		.cpu_ack(cpu_ack), .cpu_ack_id(cpu_ack_id), .unmask_all_instr(unmask),
		.mask_all_instr(mask), .return_from_maskable(ret_mask), .return_from_nmi(ret_nmi),
		.ret_imf(ret_imf), .int_req(int_req), .int_id(int_id), .pushed_imf(pushed_imf));

	ilu_cpu_model cpu (.sys_clk(sys_clk), .pushed_imf(pushed_imf), .cpu_ack(cpu_ack),
		.cpu_ack_id(cpu_ack_id), .ret_mask(ret_mask), .ret_nmi(ret_nmi), .ret_imf(ret_imf));

	////////////////////////////////////////////////////////////////////////////////
	// access and compare tasks, all entered 1 ns after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
		// idle edge: a following call must not raise the strobe in this time step
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read data is registered, so it is looked at one edge after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
		@(posedge sys_clk);
		#1;
	endtask

	task automatic req(input logic r, input logic [3:0] id);
		chk({7'h00, int_req}, {7'h00, r});
		chk({4'h0, int_id}, {4'h0, id});
	endtask

	task automatic irq(input logic [15:0] m);
		irq_src = m[15:2];
		@(posedge sys_clk);
		#1;
		irq_src = '0;
	endtask

	task automatic instr(input logic on);
		unmask = on;
		mask = ~on;
		@(posedge sys_clk);
		#1;
		unmask = 1'b0;
		mask = 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// hang guard: the whole sequence needs far fewer cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		rchk(`ILU_ENABLE_LOW_ADDR, 8'h00);
		rchk(`ILU_ENABLE_HIGH_ADDR, 8'h00);
		rchk(`ILU_LATCH_LOW_ADDR, 8'h00);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h00);
		req(1'b0, 4'h0);
		wr(8'h3e, 8'hff);
		rchk(8'h3e, 8'h00);
		wr(`ILU_ENABLE_LOW_ADDR, 8'h0e);
		rchk(`ILU_ENABLE_LOW_ADDR, 8'h00);
		$display("test reset_and_map done");
		// trap and watchdog need no enable; source 9 stays blocked
		irq(16'h020c);
		req(1'b1, 4'h2);
		cpu.accept(4'h2);
		chk({7'h00, pushed_imf}, 8'h00);
		req(1'b1, 4'h3);
		cpu.accept(4'h3);
		rchk(`ILU_LATCH_LOW_ADDR, 8'h00);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h02);
		req(1'b0, 4'h0);
		cpu.ret(1'b1);
		cpu.ret(1'b1);
		$display("test nonmaskable done");
		// per-source enables written apart from the global enable
		wr(`ILU_ENABLE_LOW_ADDR, 8'h30);
		wr(`ILU_ENABLE_HIGH_ADDR, 8'h02);
		rchk(`ILU_ENABLE_HIGH_ADDR, 8'h02);
		req(1'b0, 4'h0);
		instr(1'b1);
		req(1'b1, 4'h9);
		irq(16'h1020);
		req(1'b1, 4'h5);
		rchk(`ILU_ENABLE_LOW_ADDR, 8'h31);
		cpu.accept(int_id);
		chk({7'h00, pushed_imf}, 8'h01);
		req(1'b0, 4'h0);
		rchk(`ILU_ENABLE_LOW_ADDR, 8'h30);
		rchk(`ILU_LATCH_LOW_ADDR, 8'h00);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h12);
		cpu.ret(1'b0);
		req(1'b1, 4'h9);
		cpu.accept(4'h0);
		req(1'b0, 4'h0);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h12);
		cpu.ret(1'b1);
		req(1'b1, 4'h9);
		instr(1'b0);
		req(1'b0, 4'h0);
		$display("test maskable done");
		// writes clear latches at zero bits and keep them at ones; a request in the write cycle wins
		irq(16'h0050);
		wr(`ILU_LATCH_LOW_ADDR, 8'hbf);
		rchk(`ILU_LATCH_LOW_ADDR, 8'h10);
		wr(`ILU_LATCH_HIGH_ADDR, 8'hef);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h02);
		wr(`ILU_LATCH_HIGH_ADDR, 8'hff);
		rchk(`ILU_LATCH_HIGH_ADDR, 8'h02);
		fork
			irq(16'h0080);
			wr(`ILU_LATCH_LOW_ADDR, 8'h6f);
		join
		rchk(`ILU_LATCH_LOW_ADDR, 8'h80);
		wr(`ILU_ENABLE_HIGH_ADDR, 8'h00);
		instr(1'b1);
		req(1'b0, 4'h0);
		$display("test latch_clear done");
		tally_and_finish();
	end
endmodule
